// ---- logic/cc_pkg.sv ----
`default_nettype none
package cc_pkg;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ST_TIME_US = 100;
    localparam int ST_CYCLES_DEF = (ST_TIME_US * 1000) / CLK_PERIOD_NS;

    // command codes
    localparam logic [3:0] CMD_RST = 4'h1;
    localparam logic [3:0] CMD_SAV = 4'h2;
    localparam logic [3:0] CMD_RCL = 4'h3;
    localparam logic [3:0] CMD_SVC_EN = 4'h4;
    localparam logic [3:0] CMD_SVC_ENQ = 4'h5;
    localparam logic [3:0] CMD_STBQ = 4'h6;
    localparam logic [3:0] CMD_TSTQ = 4'h7;
    localparam logic [3:0] CMD_WAI = 4'h8;
    localparam logic [3:0] CMD_CLS = 4'h9;

    // memory slots
    localparam logic [3:0] SLOT_DEFAULT = 4'h0;
    localparam logic [3:0] SLOT_FIRST = 4'h1;
    localparam logic [3:0] SLOT_LAST = 4'h9;
    localparam int SLOT_N = 9;

    // status byte and enable register layout
    localparam int SUM_OPER = 7;
    localparam int SUM_RQS = 6;
    localparam int SUM_ESB = 5;
    localparam int SUM_MAV = 4;
    localparam int SUM_QUES = 3;
    localparam logic [7:0] SVC_GATE_MASK = 8'hb8;
    localparam logic [7:0] SVC_EN_RESET = 8'h00;

    // self-test result
    localparam int FAIL_W = 9;
    localparam int RES_W = 16;

    // setting fields, values in hundredths of dB, nm, ms or codes
    localparam int SET_W = 172;
    localparam logic [15:0] ATT_DEF = 16'h0000;
    localparam logic [15:0] CAL_DEF = 16'h0000;
    localparam logic [15:0] WVL_DEF = 16'h051e;
    localparam logic SWEEP_AUTO_DEF = 1'b0;
    localparam logic [15:0] START_DEF = 16'h0000;
    localparam logic [15:0] STOP_DEF = 16'h0000;
    localparam logic [15:0] STEP_DEF = 16'h0000;
    localparam logic [15:0] DWELL_DEF = 16'h00c8;
    localparam logic [15:0] INS_LOSS_DEF = 16'h00c8;
    localparam logic [15:0] RETURN_LOSS_REFERENCE_DEF = 16'h05be;
    localparam logic [15:0] RETURN_LOSS_INPUT_DEF = 16'h1770;
    localparam logic LCAL_DEF = 1'b0;
    localparam logic UCAL_DEF = 1'b0;
    localparam logic THRU_DEF = 1'b0;
    localparam logic [2:0] BRIGHT_DEF = 3'h6;
    localparam logic PON_LAST_DEF = 1'b1;
    localparam logic SHUT_NORM_DEF = 1'b1;
    localparam logic SHUT_PON_DEF = 1'b0;
    localparam logic [1:0] RES_HUNDREDTH = 2'h2;

    localparam logic [SET_W-1:0] SET_DEF = {ATT_DEF, CAL_DEF, WVL_DEF, SWEEP_AUTO_DEF,
        START_DEF, STOP_DEF, STEP_DEF, DWELL_DEF, INS_LOSS_DEF, RETURN_LOSS_REFERENCE_DEF,
        RETURN_LOSS_INPUT_DEF, LCAL_DEF, UCAL_DEF, THRU_DEF, BRIGHT_DEF, PON_LAST_DEF,
        SHUT_NORM_DEF, SHUT_PON_DEF, RES_HUNDREDTH};

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_TEST = 3'h2,
        ST_WAIT = 3'h4
    } cc_state_t;

    function automatic logic cc_slot_ok(input logic [7:0] arg);
        return (arg >= {4'h0, SLOT_FIRST}) && (arg <= {4'h0, SLOT_LAST});
    endfunction

endpackage
`default_nettype wire

// ---- logic/cc_slot_store.sv ----
`timescale 1ns/10ps
`default_nettype none
module cc_slot_store import cc_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // write side
    input wire logic wr_en,
    input wire logic [3:0] wr_slot,
    input wire logic [SET_W-1:0] wr_data,
    // read side
    input wire logic [3:0] rd_slot,
    output logic [SET_W-1:0] rd_data
);
    logic [SET_W-1:0] mem [SLOT_N];
    logic [SLOT_N-1:0] used_ff;

    function automatic int slot_idx(input logic [3:0] s);
        return int'(s) - int'(SLOT_FIRST);
    endfunction

    always_ff @(posedge clock) begin
        if (wr_en && wr_slot >= SLOT_FIRST && wr_slot <= SLOT_LAST) begin
            mem[slot_idx(wr_slot)] <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            used_ff <= '0;
        end else if (wr_en && wr_slot >= SLOT_FIRST && wr_slot <= SLOT_LAST) begin
            used_ff[slot_idx(wr_slot)] <= 1'b1;
        end
    end

    // slot 0 and never written slots give the default setting
    always_comb begin
        rd_data = SET_DEF;
        if (rd_slot >= SLOT_FIRST && rd_slot <= SLOT_LAST) begin
            if (used_ff[slot_idx(rd_slot)]) begin
                rd_data = mem[slot_idx(rd_slot)];
            end
        end
    end

    save_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        wr_en && wr_slot >= SLOT_FIRST && wr_slot <= SLOT_LAST && rd_slot == wr_slot
        |=> rd_slot != $past(wr_slot) || rd_data == $past(wr_data))
        else $error("saved setting not read back");
endmodule
`default_nettype wire

// ---- logic/cc_self_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module cc_self_test import cc_pkg::*; #(
    parameter int ST_CYCLES = ST_CYCLES_DEF
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // control
    input wire logic start,
    output logic busy,
    output logic done,
    // results
    input wire logic [FAIL_W-1:0] fail_flags,
    output logic [RES_W-1:0] result
);
    localparam logic [31:0] LAST = 32'(ST_CYCLES - 1);
    logic [31:0] cnt_ff;
    logic busy_ff;
    logic done_ff;
    logic [RES_W-1:0] result_ff;

    // runs by itself once started, no operator step
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busy_ff <= 1'b0;
            cnt_ff <= '0;
        end else if (start && !busy_ff) begin
            busy_ff <= 1'b1;
            cnt_ff <= '0;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff + 32'h1;
            if (cnt_ff == LAST) begin
                busy_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            done_ff <= 1'b0;
            result_ff <= '0;
        end else begin
            done_ff <= busy_ff && cnt_ff == LAST;
            if (busy_ff && cnt_ff == LAST) begin
                result_ff <= RES_W'(fail_flags);
            end
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;
    assign result = result_ff;

    zero_result_a: assert property (@(posedge clock) disable iff (!arst_n)
        busy_ff && cnt_ff == LAST && fail_flags == '0 |=> result_ff == '0 && done_ff)
        else $error("self-test result not zero with no failures");
endmodule
`default_nettype wire

// ---- logic/cc_common_unit.sv ----
`timescale 1ns/10ps
`default_nettype none
module cc_common_unit import cc_pkg::*; #(
    parameter int ST_CYCLES = ST_CYCLES_DEF
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // command port
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    input wire logic [7:0] cmd_arg,
    output logic cmd_ready,
    // answer port
    output logic resp_valid,
    output logic [RES_W-1:0] resp_data,
    // instrument setting
    input wire logic set_wr,
    input wire logic [SET_W-1:0] set_wdata,
    output logic [SET_W-1:0] cur_set,
    // status summaries
    input wire logic oper_sum,
    input wire logic esb_sum,
    input wire logic mav_sum,
    input wire logic ques_sum,
    output logic [7:0] status_summary_byte,
    output logic [7:0] service_request_enable,
    output logic srq,
    // operations and self-test
    input wire logic pending_ops,
    input wire logic [FAIL_W-1:0] fail_flags,
    output logic test_busy
);
    cc_state_t state_ff;
    cc_state_t nxt_state;
    logic [SET_W-1:0] cur_set_ff;
    logic [SET_W-1:0] snap_ff;
    logic [7:0] svc_en_ff;
    logic resp_valid_ff;
    logic [RES_W-1:0] resp_data_ff;
    logic take;
    logic [7:0] sum_raw;
    logic rqs;
    logic st_start;
    logic st_busy;
    logic st_done;
    logic [RES_W-1:0] st_result;
    logic [SET_W-1:0] slot_rdata;

    function automatic logic is_cmd(input logic t, input logic [3:0] c, input logic [3:0] k);
        return t && c == k;
    endfunction

    // no command taken outside idle
    assign cmd_ready = state_ff == ST_IDLE;
    assign take = cmd_valid && cmd_ready;
    assign st_start = is_cmd(take, cmd_code, CMD_TSTQ);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (st_start) begin
                    nxt_state = ST_TEST;
                end else if (is_cmd(take, cmd_code, CMD_WAI)) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_TEST: begin
                if (st_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (!pending_ops) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    cc_self_test #(
        .ST_CYCLES(ST_CYCLES)
    ) u_test (
        .clock(clock),
        .arst_n(arst_n),
        .start(st_start),
        .busy(st_busy),
        .done(st_done),
        .fail_flags(fail_flags),
        .result(st_result)
    );

    cc_slot_store u_store (
        .clock(clock),
        .arst_n(arst_n),
        .wr_en(is_cmd(take, cmd_code, CMD_SAV) && cc_slot_ok(cmd_arg)),
        .wr_slot(cmd_arg[3:0]),
        .wr_data(cur_set_ff),
        .rd_slot(cmd_arg[3:0]),
        .rd_data(slot_rdata)
    );

    // setting snapshot taken when the self-test query is processed
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            snap_ff <= SET_DEF;
        end else if (st_start) begin
            snap_ff <= cur_set_ff;
        end
    end

    // active setting; restore after test wins over everything else
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cur_set_ff <= SET_DEF;
        end else if (st_done) begin
            cur_set_ff <= snap_ff;
        end else if (is_cmd(take, cmd_code, CMD_RST)) begin
            cur_set_ff <= SET_DEF;
        end else if (is_cmd(take, cmd_code, CMD_RCL) && cmd_arg[7:4] == 4'h0
            && cmd_arg[3:0] <= SLOT_LAST) begin
            cur_set_ff <= slot_rdata;
        end else if (set_wr) begin
            cur_set_ff <= set_wdata;
        end
    end

    // enable register: only its own command writes it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            svc_en_ff <= SVC_EN_RESET;
        end else if (is_cmd(take, cmd_code, CMD_SVC_EN)) begin
            svc_en_ff <= cmd_arg;
        end
    end

    always_comb begin
        sum_raw = '0;
        sum_raw[SUM_OPER] = oper_sum;
        sum_raw[SUM_ESB] = esb_sum;
        sum_raw[SUM_MAV] = mav_sum;
        sum_raw[SUM_QUES] = ques_sum;
    end

    // bit 6 of the enable register is masked out of the gate
    assign rqs = |(sum_raw & svc_en_ff & SVC_GATE_MASK);

    always_comb begin
        status_summary_byte = sum_raw;
        status_summary_byte[SUM_RQS] = rqs;
    end

    // answers for the three queries
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            resp_valid_ff <= 1'b0;
            resp_data_ff <= '0;
        end else begin
            resp_valid_ff <= 1'b0;
            if (st_done) begin
                resp_valid_ff <= 1'b1;
                resp_data_ff <= st_result;
            end else if (is_cmd(take, cmd_code, CMD_SVC_ENQ)) begin
                resp_valid_ff <= 1'b1;
                resp_data_ff <= RES_W'(svc_en_ff);
            end else if (is_cmd(take, cmd_code, CMD_STBQ)) begin
                resp_valid_ff <= 1'b1;
                resp_data_ff <= RES_W'(status_summary_byte);
            end
        end
    end

    assign resp_valid = resp_valid_ff;
    assign resp_data = resp_data_ff;
    assign cur_set = cur_set_ff;
    assign service_request_enable = svc_en_ff;
    assign srq = rqs;
    assign test_busy = st_busy;

    // checks
    sequence test_taken_s;
        st_start;
    endsequence

    sequence test_ends_s;
        st_done && state_ff == ST_TEST;
    endsequence

    en_write_a: assert property (@(posedge clock) disable iff (!arst_n)
        is_cmd(take, cmd_code, CMD_SVC_EN) |=> svc_en_ff == $past(cmd_arg))
        else $error("enable register write lost");

    en_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        (is_cmd(take, cmd_code, CMD_RST) || is_cmd(take, cmd_code, CMD_CLS))
        |=> $stable(svc_en_ff))
        else $error("enable register changed by reset or clear");

    en_zero_a: assert property (@(posedge clock) disable iff (!arst_n)
        is_cmd(take, cmd_code, CMD_SVC_EN) && cmd_arg == 8'h00 |=> svc_en_ff == 8'h00)
        else $error("enable register not cleared");

    en_keep_a: assert property (@(posedge clock) disable iff (!arst_n)
        !is_cmd(take, cmd_code, CMD_SVC_EN) |=> $stable(svc_en_ff))
        else $error("enable register changed by another command");

    rqs_gate_a: assert property (@(posedge clock) disable iff (!arst_n)
        srq == ((oper_sum && svc_en_ff[SUM_OPER]) || (esb_sum && svc_en_ff[SUM_ESB])
            || (mav_sum && svc_en_ff[SUM_MAV]) || (ques_sum && svc_en_ff[SUM_QUES]))
        && status_summary_byte[SUM_RQS] == srq)
        else $error("request service bit wrong");

    bit_six_a: assert property (@(posedge clock) disable iff (!arst_n)
        svc_en_ff[SUM_RQS] && sum_raw == 8'h00 |-> !srq)
        else $error("enable bit 6 gated a request");

    rst_default_a: assert property (@(posedge clock) disable iff (!arst_n)
        is_cmd(take, cmd_code, CMD_RST) && !st_done |=> cur_set_ff == SET_DEF)
        else $error("default setting not loaded");

    test_block_a: assert property (@(posedge clock) disable iff (!arst_n)
        st_busy || st_done |-> !cmd_ready)
        else $error("command accepted during self-test");

    test_start_a: assert property (@(posedge clock) disable iff (!arst_n)
        test_taken_s |=> st_busy && !cmd_ready)
        else $error("self-test did not start by itself");

    test_snap_a: assert property (@(posedge clock) disable iff (!arst_n)
        test_taken_s |=> snap_ff == $past(cur_set_ff))
        else $error("setting not captured at self-test query");

    test_answer_a: assert property (@(posedge clock) disable iff (!arst_n)
        test_ends_s |=> resp_valid_ff && resp_data_ff == $past(st_result))
        else $error("self-test result not queued");

    test_flags_a: assert property (@(posedge clock) disable iff (!arst_n)
        test_ends_s |=> resp_data_ff == RES_W'($past(fail_flags, 2)))
        else $error("self-test result weights wrong");

    test_restore_a: assert property (@(posedge clock) disable iff (!arst_n)
        test_ends_s |=> cur_set_ff == $past(snap_ff) && resp_valid_ff)
        else $error("setting not restored after self-test");

    wai_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        state_ff == ST_WAIT && pending_ops |-> !cmd_ready)
        else $error("command taken while operations pending");

    query_answer_a: assert property (@(posedge clock) disable iff (!arst_n)
        is_cmd(take, cmd_code, CMD_SVC_ENQ) |=> resp_valid_ff
        && resp_data_ff == RES_W'($past(svc_en_ff)))
        else $error("enable query answer wrong");

    stb_answer_a: assert property (@(posedge clock) disable iff (!arst_n)
        is_cmd(take, cmd_code, CMD_STBQ) |=> resp_valid_ff
        && resp_data_ff == RES_W'($past(status_summary_byte)))
        else $error("status query answer wrong");

    rcl_default_a: assert property (@(posedge clock) disable iff (!arst_n)
        is_cmd(take, cmd_code, CMD_RCL) && cmd_arg == 8'h00 |=> cur_set_ff == SET_DEF)
        else $error("slot 0 did not give the default setting");

    rst_keep_a: assert property (@(posedge clock) disable iff (!arst_n)
        is_cmd(take, cmd_code, CMD_RST) |=> $stable(resp_data_ff))
        else $error("reset command changed the answer");

    wai_enter_a: assert property (@(posedge clock) disable iff (!arst_n)
        is_cmd(take, cmd_code, CMD_WAI) |=> !cmd_ready)
        else $error("command taken right after wait");

    wai_leave_a: assert property (@(posedge clock) disable iff (!arst_n)
        state_ff == ST_WAIT && !pending_ops |=> cmd_ready)
        else $error("wait not left after operations completed");
endmodule
`default_nettype wire

// ---- verification/cc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module cc_host_model import cc_pkg::*; (
    // clock
    input wire logic clock,
    // command port
    output var logic cmd_valid,
    output var logic [3:0] cmd_code,
    output var logic [7:0] cmd_arg,
    input wire logic cmd_ready,
    // answer port
    input wire logic resp_valid,
    input wire logic [RES_W-1:0] resp_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 4'h0;
        cmd_arg = 8'h00;
    end

    // request stands until the edge that sees cmd_ready high
    task automatic send(input logic [3:0] code, input logic [7:0] arg);
        @(negedge clock);
        cmd_code = code;
        cmd_arg = arg;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1) begin
            @(negedge clock);
        end
        @(posedge clock);
    endtask

    // released lines show the inverse of the last value
    task automatic release_cmd();
        @(negedge clock);
        cmd_valid = 1'b0;
        cmd_code = ~cmd_code;
        cmd_arg = ~cmd_arg;
    endtask

    // nothing more is sent until the answer arrives
    task automatic ask(input logic [3:0] code, input logic [7:0] arg,
            output logic [RES_W-1:0] data, output int lat);
        send(code, arg);
        release_cmd();
        // the answer pulse already stands in the cycle after the taking edge
        lat = 1;
        while (resp_valid !== 1'b1 && lat < 1000) begin
            @(negedge clock);
            lat++;
        end
        data = resp_data;
    endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top import cc_pkg::*;;
    localparam int ST_N = 8;
    logic clock, arst_n, set_wr, pending_ops, cmd_valid, cmd_ready, resp_valid, srq, test_busy;
    logic [3:0] cmd_code;
    logic [7:0] cmd_arg, sum_v, status_summary_byte, service_request_enable, b, en, ex;
    logic [RES_W-1:0] resp_data, d;
    logic [SET_W-1:0] set_wdata, cur_set, set_a, set_b;
    logic [FAIL_W-1:0] fail_flags, fl;
    int lat;
    int n_errors = 0;
    int n_checks = 0;

    cc_common_unit #(.ST_CYCLES(ST_N)) dut_u (
        .clock(clock), .arst_n(arst_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
        .resp_valid(resp_valid), .resp_data(resp_data),
        .set_wr(set_wr), .set_wdata(set_wdata), .cur_set(cur_set),
        .oper_sum(sum_v[7]), .esb_sum(sum_v[5]), .mav_sum(sum_v[4]), .ques_sum(sum_v[3]),
        .status_summary_byte(status_summary_byte),
        .service_request_enable(service_request_enable), .srq(srq),
        .pending_ops(pending_ops), .fail_flags(fail_flags), .test_busy(test_busy)
    );

    cc_host_model host_u (
        .clock(clock), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
        .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_data(resp_data)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic cmd(input logic [3:0] code, input logic [7:0] arg);
        host_u.send(code, arg);
        host_u.release_cmd();
    endtask

    task automatic query(input logic [3:0] code, input logic [RES_W-1:0] exp, input string what);
        logic [RES_W-1:0] q;
        int l;
        host_u.ask(code, 8'h00, q, l);
        chk(q === exp && l == 1, what);
    endtask

    task automatic put_set(input logic [SET_W-1:0] v);
        @(negedge clock);
        set_wdata = v;
        set_wr = 1'b1;
        @(negedge clock);
        set_wr = 1'b0;
        set_wdata = ~v;
    endtask

    initial begin
        int cyc;
        cyc = 0;
        forever begin
            @(posedge clock);
            cyc++;
            if (cyc >= 5000) begin
                n_errors++;
                $display("CHECK FAILED at %0t: run did not finish", $time);
                conclude();
            end
        end
    end

    initial begin
        arst_n = 1'b0;
        set_wr = 1'b0;
        set_wdata = '0;
        sum_v = 8'h00;
        pending_ops = 1'b0;
        fail_flags = '0;
        set_a = {43{4'h5}};
        set_b = {43{4'h3}};
        repeat (5) @(posedge clock);
        @(negedge clock);
        arst_n = 1'b1;
        // power-on setting and enable register
        chk(cur_set[171:140] === 32'h0 && cur_set[139:124] === 16'h051e, "levels");
        chk(cur_set[123:75] === 49'h0 && cur_set[74:59] === 16'h00c8, "sweep");
        chk(cur_set[58:11] === 48'h00c8_05be_1770, "return loss");
        chk(cur_set[10:0] === 11'h0da && cur_set === SET_DEF, "modes");
        query(CMD_SVC_ENQ, 16'h0000, "enable at power-on");
        // enable writes back to back with read back
        for (int i = 0; i < 4; i++) begin
            en = (i == 0) ? 8'h30 : (i == 1) ? 8'hff : (i == 2) ? 8'h40 : 8'h00;
            host_u.send(CMD_SVC_EN, en);
            query(CMD_SVC_ENQ, {8'h00, en}, "enable read back");
        end
        // each summary gated by its own enable bit, bit 6 never gates
        for (int i = 0; i < 4; i++) begin
            b = (i == 0) ? 8'h80 : (i == 1) ? 8'h20 : (i == 2) ? 8'h10 : 8'h08;
            @(negedge clock);
            sum_v = b;
            for (int j = 0; j < 2; j++) begin
                en = (j == 0) ? b : ~b;
                ex = (j == 0) ? (b | 8'h40) : b;
                cmd(CMD_SVC_EN, en);
                chk(srq === (j == 0) && status_summary_byte === ex, "gating");
                query(CMD_STBQ, {8'h00, ex}, "status query");
            end
        end
        // reset and clear-status keep the enable register and the answer
        put_set(set_a);
        cmd(CMD_RST, 8'h00);
        chk(cur_set === SET_DEF, "reset loads default");
        cmd(CMD_CLS, 8'h00);
        query(CMD_SVC_ENQ, 16'h00f7, "enable kept");
        cmd(CMD_RST, 8'h00);
        chk(resp_data === 16'h00f7 && service_request_enable === 8'hf7, "reset keeps");
        // save and recall at the slot range ends
        put_set(set_a);
        cmd(CMD_SAV, 8'h01);
        put_set(set_b);
        cmd(CMD_SAV, 8'h09);
        cmd(CMD_RST, 8'h00);
        cmd(CMD_RCL, 8'h01);
        chk(cur_set === set_a, "slot 1");
        cmd(CMD_RCL, 8'h09);
        chk(cur_set === set_b, "slot 9");
        cmd(CMD_RCL, 8'h0a);
        chk(cur_set === set_b, "slot 10 ignored");
        cmd(CMD_RCL, 8'h00);
        chk(cur_set === SET_DEF, "slot 0 default");
        // a slot number with high bits set must not alias onto slot 1
        cmd(CMD_SAV, 8'h11);
        cmd(CMD_RCL, 8'h01);
        chk(cur_set === set_a, "slot 17 ignored");
        // self-test: no failure, each weight alone, then two together
        put_set(set_a);
        for (int k = 0; k <= FAIL_W + 1; k++) begin
            fl = (k == 0) ? 9'h000 : (k <= FAIL_W) ? (9'h001 << (k - 1)) : 9'h012;
            @(negedge clock);
            fail_flags = fl;
            fork
                host_u.ask(CMD_TSTQ, 8'h00, d, lat);
                begin
                    repeat (3) @(negedge clock);
                    chk(cmd_ready === 1'b0 && test_busy === 1'b1, "busy");
                    put_set(set_b);
                end
            join
            chk(d === {7'h00, fl} && lat == ST_N + 2, "test result");
            chk(cur_set === set_a && test_busy === 1'b0, "restored");
        end
        // wait command holds the next command until operations finish
        @(negedge clock);
        pending_ops = 1'b1;
        cmd(CMD_SVC_EN, 8'h22);
        cmd(CMD_WAI, 8'h00);
        fork
            host_u.send(CMD_SVC_EN, 8'h11);
            begin
                repeat (4) @(negedge clock);
                chk(cmd_ready === 1'b0 && service_request_enable === 8'h22, "held");
                pending_ops = 1'b0;
            end
        join
        host_u.release_cmd();
        chk(service_request_enable === 8'h11, "resumed");
        // a second power-on clears the enable register again
        @(negedge clock);
        arst_n = 1'b0;
        @(negedge clock);
        arst_n = 1'b1;
        chk(service_request_enable === 8'h00 && cur_set === SET_DEF, "power-on clear");
        query(CMD_SVC_ENQ, 16'h0000, "enable after power-on");
        conclude();
    end
endmodule
`default_nettype wire
